/* pkg/dcr_cfg.svh */
// Constants of the diagnostic command group responder.
// Assumes inclusion by bare name from files that need codes or timing.
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

// Command group and sub-command codes
`define DCR_GROUP_DIAG     16'h0200
`define DCR_SUB_STATUS     16'h0001
`define DCR_SUB_IFSTAT     16'h0002
`define DCR_SUB_LOG_READ   16'h0003
`define DCR_SUB_LOG_COUNT  16'h0004
`define DCR_SUB_LOG_CLEAR  16'h0005
`define DCR_SUB_RSV_A      16'h0006
`define DCR_SUB_RSV_B      16'h0007

// Class prefixes, high byte of every response code
`define DCR_PFX_SYNC_OK    8'h88
`define DCR_PFX_ASYNC_OK   8'h48
`define DCR_PFX_UNSOL_OK   8'h28
`define DCR_PFX_SYNC_ERR   8'h82
`define DCR_PFX_ASYNC_ERR  8'h42
`define DCR_PFX_UNSOL_ERR  8'h22
`define DCR_PFX_SYNC_CTL   8'h81
`define DCR_PFX_ASYNC_CTL  8'h41
`define DCR_PFX_UNSOL_CTL  8'h21

// Low bytes selecting the specific response
`define DCR_LO_COMPLETE    8'h00
`define DCR_LO_PROGRESS    8'h01
`define DCR_LO_LEN_ERR     8'h00
`define DCR_LO_SEQ_ERR     8'h01
`define DCR_LO_GRP_ERR     8'h03
`define DCR_LO_TMO_ERR     8'h04
`define DCR_LO_FAIL_ERR    8'h06
`define DCR_LO_SYS_ERR     8'h07
`define DCR_LO_SUB_ERR     8'h08
`define DCR_LO_ACK_ERR     8'h09
`define DCR_LO_CTL_ERR     8'h0A
`define DCR_LO_ACK         8'h00
`define DCR_LO_NACK        8'h01
`define DCR_LO_CHG         8'h10

// Codes that must never leave the block
`define DCR_RSV_UNSOL      16'h2410
`define DCR_RSV_SYNC_OK0   16'h8800
`define DCR_RSV_SYNC_OK1   16'h8801

// Payload word counts
`define DCR_N0             2'h0
`define DCR_N1             2'h1
`define DCR_N2             2'h2
`define DCR_N3             2'h3

// Reset values
`define DCR_SEQ_RST        8'h00
`define DCR_STATUS_RST     64'h0000_0000_0000_0000

// Error bits of the 64-bit diagnostic status
`define DCR_ERR_MASK       64'h0607_CFFF_807F_FC08

// Timing
`define DCR_CLK_PERIOD_NS  10
`define DCR_EXEC_TMO_US    1000
`endif

/* pkg/dcr_pkg.sv */
// Types of the diagnostic command group responder.
// Assumes the constants header is compiled alongside.
package dcr_pkg;

    // One decoded host message
    typedef struct packed {
        logic [15:0] group;
        logic [15:0] sub;
        logic [15:0] rx_len;
        logic [15:0] exp_len;
        logic [7:0]  rx_seq;
        logic        async;
    } dcr_cmd_t;

    // One response: code and up to three payload words
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [1:0]  n;
    } dcr_rsp_t;

    // Execution result from the sub-command engine
    typedef struct packed {
        logic        fail;
        logic [15:0] module_num;
        logic [15:0] error_num;
    } dcr_res_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DONE
    } dcr_state_t;

endpackage

/* rtl/dcr_word_tx.sv */
// Response serialiser: code word first, then payload words.
// Assumes load only while busy is low.
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_word_tx (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst,
    // Load side
    input  wire logic            load,
    input  wire dcr_pkg::dcr_rsp_t rsp,
    output wire logic            busy,
    // Word stream
    output logic                 rsp_valid,
    output logic [15:0]          rsp_word,
    output logic                 rsp_first,
    output wire logic            rsp_last,
    input  wire logic            rsp_ready
);
    logic [1:0]  rem;
    logic [47:0] queue;

    assign busy     = rsp_valid;
    assign rsp_last = rsp_valid && (rem == `DCR_N0);

    // Shift out one word per accepted beat; all payload is captured at load,
    // since the load-side response is only valid in the load cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_word  <= 16'h0000;
            rsp_first <= 1'b0;
            rem       <= `DCR_N0;
            queue     <= 48'h0000_0000_0000;
        end else if (load) begin
            rsp_valid <= 1'b1;
            rsp_word  <= rsp.code;
            rsp_first <= 1'b1;
            rem       <= rsp.n;
            queue     <= {rsp.w0, rsp.w1, rsp.w2};
        end else if (rsp_valid && rsp_ready) begin
            rsp_first <= 1'b0;
            if (rem == `DCR_N0) begin
                rsp_valid <= 1'b0;
            end else begin
                rem      <= rem - `DCR_N1;
                rsp_word <= queue[47:32];
                queue    <= {queue[31:0], 16'h0000};
            end
        end
    end
endmodule

/* rtl/dcr_chg_watch.sv */
// Diagnostic status change watcher for unsolicited reports.
// Assumes take pulses in the cycle the report is loaded.
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_chg_watch (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Status and report handshake
    input  wire logic [63:0] status,
    input  wire logic        take,
    output wire logic        pend,
    output wire logic        err_form
);
    logic [63:0] last_rep;

    // Report only a value different from the one last sent
    assign pend     = (status != last_rep);
    assign err_form = |(status & `DCR_ERR_MASK);

    // Remember what was reported
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_rep <= `DCR_STATUS_RST;
        end else if (take) begin
            last_rep <= status;
        end
    end
endmodule

/* rtl/dcr_responder.sv */
// Diagnostic command group responder: checks and decodes host messages,
// drives the sub-command engine and emits response word streams.
// Assumes framing upstream and an engine that pulses exec_done once.
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_responder #(
    parameter int EXEC_TMO_CYC = `DCR_EXEC_TMO_US * 1000 / `DCR_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Host message in
    input  wire logic                cmd_valid,
    input  wire dcr_pkg::dcr_cmd_t   cmd,
    output wire logic                cmd_ready,
    // Host data acknowledge in
    input  wire logic                ack_valid,
    input  wire logic [15:0]         ack_word,
    output wire logic                ack_ready,
    output logic                     ack_ok,
    output logic                     ack_nack,
    // Sub-command engine
    output logic                     exec_start,
    output logic [15:0]              exec_sub,
    input  wire logic                exec_done,
    input  wire dcr_pkg::dcr_res_t   exec_res,
    // System events
    input  wire logic                sys_err,
    input  wire logic                ctl_err,
    input  wire logic [63:0]         diag_status,
    // Response word stream
    output wire logic                rsp_valid,
    output wire logic [15:0]         rsp_word,
    output wire logic                rsp_first,
    output wire logic                rsp_last,
    input  wire logic                rsp_ready
);
    localparam logic [31:0] TMO_LAST = 32'(EXEC_TMO_CYC - 1);

    dcr_pkg::dcr_state_t state;
    dcr_pkg::dcr_rsp_t   next_rsp;
    dcr_pkg::dcr_rsp_t   fin_rsp;
    logic [7:0]          exp_seq;
    logic [31:0]         tmo_cnt;
    logic                busy;
    logic                load;
    logic                chg_take;
    logic                chg_pend;
    logic                chg_err;
    logic                sys_pend;
    logic                ctl_pend;
    logic                cmd_fire;
    logic                ack_fire;
    logic                len_bad;
    logic                seq_bad;
    logic                grp_bad;
    logic                sub_ok;
    logic                sub_rsv;
    logic                tmo_hit;
    logic [7:0]          err_pfx;

    // Acknowledges are taken ahead of new messages
    assign ack_ready = (state == dcr_pkg::ST_IDLE) && !busy;
    assign cmd_ready = ack_ready && !ack_valid;
    assign ack_fire  = ack_valid && ack_ready;
    assign cmd_fire  = cmd_valid && cmd_ready;

    // Message checks in priority order: length, sequence, group, sub-code
    assign len_bad = (cmd.rx_len != cmd.exp_len);
    assign seq_bad = (cmd.rx_seq != exp_seq);
    assign grp_bad = (cmd.group != `DCR_GROUP_DIAG);
    assign sub_ok  = (cmd.sub >= `DCR_SUB_STATUS) && (cmd.sub <= `DCR_SUB_LOG_CLEAR);
    assign sub_rsv = (cmd.sub == `DCR_SUB_RSV_A) || (cmd.sub == `DCR_SUB_RSV_B);
    assign err_pfx = cmd.async ? `DCR_PFX_ASYNC_ERR : `DCR_PFX_SYNC_ERR;
    assign tmo_hit = (tmo_cnt == TMO_LAST);

    // Response selection for the idle state and the final answer
    always_comb begin
        next_rsp = '0;
        load     = 1'b0;
        chg_take = 1'b0;
        if (state == dcr_pkg::ST_DONE) begin
            load     = !busy;
            next_rsp = fin_rsp;
        end else if (state == dcr_pkg::ST_IDLE && !busy) begin
            if (ack_fire) begin
                if (ack_word != {`DCR_PFX_SYNC_CTL, `DCR_LO_ACK} &&
                    ack_word != {`DCR_PFX_SYNC_CTL, `DCR_LO_NACK}) begin
                    load          = 1'b1;
                    next_rsp.code = {`DCR_PFX_SYNC_ERR, `DCR_LO_ACK_ERR};
                    next_rsp.w0   = ack_word;
                    next_rsp.n    = `DCR_N1;
                end
            end else if (cmd_fire) begin
                load = 1'b1;
                if (len_bad) begin
                    next_rsp.code = {err_pfx, `DCR_LO_LEN_ERR};
                    next_rsp.w0   = cmd.exp_len;
                    next_rsp.w1   = cmd.rx_len;
                    next_rsp.n    = `DCR_N2;
                end else if (seq_bad) begin
                    next_rsp.code = {err_pfx, `DCR_LO_SEQ_ERR};
                    next_rsp.w0   = {exp_seq, cmd.rx_seq};
                    next_rsp.n    = `DCR_N1;
                end else if (grp_bad) begin
                    next_rsp.code = {err_pfx, `DCR_LO_GRP_ERR};
                    next_rsp.w0   = cmd.group;
                    next_rsp.n    = `DCR_N1;
                end else if (sub_ok) begin
                    next_rsp.code = {`DCR_PFX_ASYNC_OK, `DCR_LO_PROGRESS};
                    next_rsp.w0   = cmd.sub;
                    next_rsp.n    = `DCR_N1;
                end else begin
                    // Reserved and unknown sub-codes alike
                    next_rsp.code = {`DCR_PFX_ASYNC_ERR, `DCR_LO_SUB_ERR};
                    next_rsp.w0   = cmd.sub;
                    next_rsp.n    = `DCR_N1;
                end
            end else if (sys_pend) begin
                load          = 1'b1;
                next_rsp.code = {`DCR_PFX_ASYNC_ERR, `DCR_LO_SYS_ERR};
            end else if (ctl_pend) begin
                load          = 1'b1;
                next_rsp.code = {`DCR_PFX_ASYNC_ERR, `DCR_LO_CTL_ERR};
            end else if (chg_pend) begin
                load          = 1'b1;
                chg_take      = 1'b1;
                // Never the reserved 24 class
                next_rsp.code = chg_err ? {`DCR_PFX_UNSOL_ERR, `DCR_LO_CHG}
                                        : {`DCR_PFX_UNSOL_OK, `DCR_LO_CHG};
            end
        end
    end

    // Control flow of one command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= dcr_pkg::ST_IDLE;
        end else begin
            case (state)
                dcr_pkg::ST_IDLE: begin
                    if (cmd_fire && !len_bad && !seq_bad && !grp_bad && sub_ok) begin
                        state <= dcr_pkg::ST_EXEC;
                    end
                end
                dcr_pkg::ST_EXEC: begin
                    if (exec_done || tmo_hit) begin
                        state <= dcr_pkg::ST_DONE;
                    end
                end
                dcr_pkg::ST_DONE: begin
                    if (!busy) begin
                        state <= dcr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= dcr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Engine start strobe and the sub-code it works on
    always_ff @(posedge core_clk) begin
        if (rst) begin
            exec_start <= 1'b0;
            exec_sub   <= 16'h0000;
        end else begin
            exec_start <= cmd_fire && !len_bad && !seq_bad && !grp_bad && sub_ok;
            if (cmd_fire) begin
                exec_sub <= cmd.sub;
            end
        end
    end

    // Time-out counter, cleared whenever no command runs
    always_ff @(posedge core_clk) begin
        if (rst || state != dcr_pkg::ST_EXEC) begin
            tmo_cnt <= 32'h0000_0000;
        end else begin
            tmo_cnt <= tmo_cnt + 32'h0000_0001;
        end
    end

    // Final answer is latched since exec_done is a single pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fin_rsp <= '0;
        end else if (state == dcr_pkg::ST_EXEC) begin
            if (exec_done && exec_res.fail) begin
                fin_rsp.code <= {`DCR_PFX_ASYNC_ERR, `DCR_LO_FAIL_ERR};
                fin_rsp.w0   <= exec_sub;
                fin_rsp.n    <= `DCR_N1;
            end else if (exec_done) begin
                fin_rsp.code <= {`DCR_PFX_ASYNC_OK, `DCR_LO_COMPLETE};
                fin_rsp.w0   <= exec_sub;
                fin_rsp.w1   <= exec_res.module_num;
                fin_rsp.w2   <= exec_res.error_num;
                fin_rsp.n    <= (exec_sub == `DCR_SUB_IFSTAT) ? `DCR_N3 : `DCR_N1;
            end else if (tmo_hit) begin
                fin_rsp.code <= {`DCR_PFX_ASYNC_ERR, `DCR_LO_TMO_ERR};
                fin_rsp.n    <= `DCR_N0;
            end
        end
    end

    // Expected sequence resynchronises to the received one plus one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            exp_seq <= `DCR_SEQ_RST;
        end else if (cmd_fire) begin
            exp_seq <= cmd.rx_seq + 8'h01;
        end
    end

    // Sticky event flags; a new event beats the clear
    // Only an idle-state load serves them, never the final answer of a command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sys_pend <= 1'b0;
            ctl_pend <= 1'b0;
        end else begin
            sys_pend <= sys_err ||
                        (sys_pend && !(load && state == dcr_pkg::ST_IDLE && !ack_fire && !cmd_fire));
            ctl_pend <= ctl_err ||
                        (ctl_pend && !(load && state == dcr_pkg::ST_IDLE && !ack_fire && !cmd_fire && !sys_pend));
        end
    end

    // Acknowledge result strobes for the transmit layer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_ok   <= 1'b0;
            ack_nack <= 1'b0;
        end else begin
            ack_ok   <= ack_fire && (ack_word == {`DCR_PFX_SYNC_CTL, `DCR_LO_ACK});
            ack_nack <= ack_fire && (ack_word == {`DCR_PFX_SYNC_CTL, `DCR_LO_NACK});
        end
    end

    dcr_chg_watch u_chg (
        .core_clk (core_clk),
        .rst      (rst),
        .status   (diag_status),
        .take     (chg_take),
        .pend     (chg_pend),
        .err_form (chg_err)
    );

    dcr_word_tx u_tx (
        .core_clk  (core_clk),
        .rst       (rst),
        .load      (load),
        .rsp       (next_rsp),
        .busy      (busy),
        .rsp_valid (rsp_valid),
        .rsp_word  (rsp_word),
        .rsp_first (rsp_first),
        .rsp_last  (rsp_last),
        .rsp_ready (rsp_ready)
    );

    // Checks on the response stream, the command state and the final answer
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    grp_err_a: assert property (cmd_fire && !len_bad && !seq_bad && grp_bad |=>
        rsp_first && rsp_word == ($past(cmd.async) ? 16'h4203 : 16'h8203))
        else $error("group error code wrong");
    len_err_a: assert property (cmd_fire && len_bad && cmd.async |=>
        rsp_word == 16'h4200 && rsp_valid)
        else $error("async length error code wrong");
    sync_len_a: assert property (cmd_fire && len_bad && !cmd.async |=>
        rsp_word == 16'h8200 && !rsp_last)
        else $error("sync length error code wrong");
    seq_err_a: assert property (cmd_fire && !len_bad && seq_bad |=>
        rsp_first && rsp_word[15:8] == $past(err_pfx) && rsp_word[7:0] == 8'h01 && !rsp_last)
        else $error("sequence error code wrong");
    prog_a: assert property (cmd_fire && !len_bad && !seq_bad && !grp_bad && sub_ok |=>
        rsp_word == 16'h4801 && exec_start && state == dcr_pkg::ST_EXEC)
        else $error("in-progress answer missing");
    sub_err_a: assert property (cmd_fire && !len_bad && !seq_bad && !grp_bad && sub_rsv |=>
        rsp_word == 16'h4208 && state == dcr_pkg::ST_IDLE)
        else $error("reserved sub-code not refused");
    tmo_a: assert property (state == dcr_pkg::ST_EXEC && tmo_hit && !exec_done |=>
        state == dcr_pkg::ST_DONE && fin_rsp.code == 16'h4204)
        else $error("time-out answer wrong");
    rsv_code_a: assert property (rsp_valid && rsp_first |-> rsp_word != `DCR_RSV_UNSOL &&
        rsp_word != `DCR_RSV_SYNC_OK0 && rsp_word != `DCR_RSV_SYNC_OK1)
        else $error("reserved code sent");
    chg_a: assert property (rsp_valid && rsp_first && $rose(rsp_valid) && rsp_word[7:0] == 8'h10 |->
        $past(chg_pend) && (rsp_word[15:8] == 8'h22) == $past(chg_err))
        else $error("status report without change");
    ack_err_a: assert property (ack_fire && ack_word != 16'h8100 && ack_word != 16'h8101 |=>
        rsp_word == 16'h8209 && !ack_ok && !ack_nack)
        else $error("bad acknowledge not reported");

    done_c: cover property (state == dcr_pkg::ST_DONE && fin_rsp.code == 16'h4800);
    tmo_c: cover property (state == dcr_pkg::ST_EXEC && tmo_hit);
    chg_c: cover property (chg_take && chg_err);
    ifst_c: cover property (rsp_valid && rsp_first && rsp_word == 16'h4800 && exec_sub == 16'h0002);
endmodule

/* sim/dcr_eng_model.sv */
// Sub-command engine model answering the responder's start pulses.
// Assumes the bench sets mode, delay and result before each start.
`timescale 1ns/1ps
module dcr_eng_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Bench control: 0 pass, 1 fail, 2 never answer
    input  wire logic [1:0]  mode,
    input  wire logic [7:0]  dly,
    input  wire logic [31:0] info,
    // Engine port
    input  wire logic        exec_start,
    output dcr_pkg::dcr_res_t exec_res,
    output logic             exec_done
);
    logic [8:0] cnt;
    // Run time count; result is scrambled outside the done cycle
    always_ff @(posedge core_clk) begin
        exec_done <= 1'b0;
        exec_res <= ~exec_res;
        if (rst) begin
            cnt <= 9'h000;
            exec_res <= '0;
        end else if (exec_start && mode != 2'h2) begin
            cnt <= {1'b0, dly} + 9'h001;
        end else if (cnt == 9'h001) begin
            cnt <= 9'h000;
            exec_done <= 1'b1;
            exec_res <= '{mode == 2'h1, info[31:16], info[15:0]};
        end else if (cnt != 9'h000) begin
            cnt <= cnt - 9'h001;
        end
    end
endmodule

/* sim/diagnostic_command_group_responder_tb_top.sv */
// Self-checking bench of the diagnostic responder with an engine model.
// Assumes responder and engine model are compiled before this file.
`timescale 1ns/1ps
module diagnostic_command_group_responder_tb_top;
    logic core_clk = 0, rst = 1, cmd_valid = 0, ack_valid = 0, sys_err = 0, ctl_err = 0, rsp_ready = 0;
    logic cmd_ready, ack_ready, ack_ok, ack_nack, exec_start, exec_done, rsp_valid, rsp_first, rsp_last;
    logic [15:0] ack_word = 16'h0000, exec_sub, rsp_word, s, w, rl, g, q[$], e[$];
    logic [63:0] diag_status = '0;
    logic [1:0] mode = 0;
    logic [7:0] dly = 0, eseq = 0, p, x;
    logic [31:0] info = 0, rnd = 32'h0001_0288, r;
    dcr_pkg::dcr_cmd_t cmd = '0;
    dcr_pkg::dcr_res_t exec_res;
    int n_fail = 0, n_checks = 0, n_ok = 0, n_nack = 0;

    always #5 core_clk = ~core_clk;

    dcr_responder #(.EXEC_TMO_CYC(50)) dcr_responder_i (.core_clk, .rst, .cmd_valid, .cmd, .cmd_ready,
        .ack_valid, .ack_word, .ack_ready, .ack_ok, .ack_nack, .exec_start, .exec_sub, .exec_done,
        .exec_res, .sys_err, .ctl_err, .diag_status, .rsp_valid, .rsp_word, .rsp_first, .rsp_last, .rsp_ready);
    dcr_eng_model dcr_eng_model_i (.core_clk, .rst, .mode, .dly, .info, .exec_start, .exec_res, .exec_done);

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Random stalls on the response side; words and ack pulses collected
    always @(posedge core_clk) begin
        rnd <= nxt(rnd);
        rsp_ready <= rnd[3] | rnd[9];
        if (!rst && rsp_valid && rsp_ready) q.push_back(rsp_word);
        if (ack_ok === 1'b1) n_ok++;
        if (ack_nack === 1'b1) n_nack++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        n_checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, expv);
        end
    endtask

    // Waits for the expected word count, then a quiet spell for extras
    task automatic drain(input string name);
        for (int i = 0; i < 600 && q.size() < e.size(); i++) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        chk(16'(q.size()), 16'(e.size()));
        foreach (e[i]) chk(q.size() > i ? q[i] : 16'hXXXX, e[i]);
        q.delete();
        e.delete();
        $display("test %s done", name);
    endtask

    // Request held until ready is seen, released at the taking edge
    task automatic hs(input bit a);
        for (int i = 0; i < 600; i++) begin
            @(negedge core_clk);
            if ((a ? ack_ready : cmd_ready) === 1'b1) break;
        end
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        ack_valid <= 1'b0;
    endtask

    task automatic send(input logic [15:0] gg, ss, rr, ee, input logic [7:0] sq, input logic as);
        @(posedge core_clk);
        cmd <= '{gg, ss, rr, ee, sq, as};
        cmd_valid <= 1'b1;
        hs(1'b0);
        eseq = sq + 8'h01;
    endtask

    task automatic send_ack(input logic [15:0] aw);
        @(posedge core_clk);
        ack_word <= aw;
        ack_valid <= 1'b1;
        hs(1'b1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        #800_000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        // Front-end errors, sync then async
        for (int a = 0; a < 2; a++) begin
            p = a ? 8'h42 : 8'h82;
            r = rnd;
            rl = {8'h01, r[7:0]};
            e = '{{p, 8'h00}, 16'h0020, rl};
            send(16'h0200, 16'h0001, rl, 16'h0020, eseq, a[0]);
            drain("length");
            x = eseq;
            e = '{{p, 8'h01}, {x, x + 8'h05}};
            send(16'h0200, 16'h0001, 16'h0010, 16'h0010, x + 8'h05, a[0]);
            drain("sequence");
            g = {r[31:17], 1'b1};
            e = '{{p, 8'h03}, g};
            send(g, 16'h0001, 16'h0010, 16'h0010, eseq, a[0]);
            drain("group");
        end
        // All sub-commands, then a failing and a hanging one
        for (int k = 0; k < 7; k++) begin
            @(posedge core_clk);
            r = rnd;
            s = (k < 5) ? 16'(k + 1) : 16'(r[1:0] + 1);
            mode <= (k < 5) ? 2'h0 : 2'(k - 4);
            dly <= r[7:0] & 8'h1F;
            info <= r;
            e = '{16'h4801, s};
            if (k < 5) e = '{16'h4801, s, 16'h4800, s};
            if (k < 5 && s == 16'h0002) e = '{16'h4801, s, 16'h4800, s, r[31:16], r[15:0]};
            if (k == 5) e = '{16'h4801, s, 16'h4206, s};
            if (k == 6) e = '{16'h4801, s, 16'h4204};
            send(16'h0200, s, 16'h0010, 16'h0010, eseq, r[8]);
            drain("subcommand");
        end
        // Reserved and out-of-range sub-codes
        for (int k = 0; k < 3; k++) begin
            s = (k < 2) ? 16'(6 + k) : (rnd[15:0] | 16'h0008);
            e = '{16'h4208, s};
            send(16'h0200, s, 16'h0010, 16'h0010, eseq, 1'b1);
            drain("reserved");
        end
        // Host acknowledge words
        w = rnd[15:0] | 16'h0002;
        send_ack(16'h8100);
        send_ack(16'h8101);
        send_ack(w);
        e = '{16'h8209, w};
        drain("ack");
        chk(16'(n_ok), 16'h0001);
        chk(16'(n_nack), 16'h0001);
        // System and control word events
        @(posedge core_clk);
        sys_err <= 1'b1;
        @(posedge core_clk);
        sys_err <= 1'b0;
        e = '{16'h4207};
        drain("system");
        ctl_err <= 1'b1;
        @(posedge core_clk);
        ctl_err <= 1'b0;
        e = '{16'h420A};
        drain("control");
        // Status changes: OK form, error form, then no change
        diag_status <= 64'h0000_0000_0000_0010;
        e = '{16'h2810};
        drain("status ok");
        diag_status <= 64'h0000_0000_0000_0018;
        e = '{16'h2210};
        drain("status error");
        diag_status <= 64'h0000_0000_0000_0018;
        drain("status same");
        tally_and_finish();
    end
endmodule
